//--- hdl/ibsl_pkg.sv
package ibsl_pkg;

    // ****************************************************************
    // widths and counts
    // ****************************************************************
    localparam int          PCT_W        = 7;       // percent 0..100
    localparam int          N_LOCAL      = 4;       // inputs 2..5
    localparam int          N_REMOTE     = 28;      // inputs 6..33
    localparam int          N_SLOT       = 5;       // slots A..E
    localparam int          SRC_W        = 6;
    localparam int          CNT_W        = 9;
    localparam int          PRE_W        = 15;
    localparam int          ADDR_W       = 8;

    // ****************************************************************
    // timing: 20 MHz clock, debounce in 50 ms steps up to 400 ms
    // ****************************************************************
    localparam int          CLK_PERIOD_NS  = 50;
    localparam int          MS_NS          = 1000000;
    localparam int          CYCLES_PER_MS  = MS_NS / CLK_PERIOD_NS;
    localparam logic [CNT_W-1:0] DEB_STEP_MS = 9'h032;  // 50 ms
    localparam logic [3:0]  DEB_CODE_MAX = 4'h8;        // 400 ms

    // ****************************************************************
    // source numbering and limits
    // ****************************************************************
    localparam logic [SRC_W-1:0] SRC_OFF    = 6'h00;
    localparam logic [SRC_W-1:0] SRC_FIRST  = 6'h02;
    localparam logic [SRC_W-1:0] SRC_LAST   = 6'h21;    // input 33
    localparam logic [SRC_W-1:0] SRC_REMOTE = 6'h06;
    localparam logic [PCT_W-1:0] PCT_FULL   = 7'h64;    // 100 %
    localparam logic [PCT_W-1:0] PCT_ZERO   = 7'h00;

    // ****************************************************************
    // register map, byte addresses
    // ****************************************************************
    localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] REG_THR    = 8'h10;   // 4 words
    localparam logic [ADDR_W-1:0] REG_ASSIGN = 8'h20;   // 5 words
    localparam logic [ADDR_W-1:0] REG_LIMIT  = 8'h40;   // 5 words

    // ctrl bits
    localparam int          CTRL_ENTRY2  = 0;
    localparam int          CTRL_ENTRY3  = 1;
    localparam int          CTRL_LATCH   = 2;
    localparam int          CTRL_ALARM   = 3;
    localparam int          CTRL_W       = 4;

    // threshold word fields, limit word uses byte k for band k
    localparam int          THR_LOW_LSB  = 0;
    localparam int          THR_MID_LSB  = 8;
    localparam int          THR_UP_LSB   = 16;
    localparam int          THR_DEB_LSB  = 24;
    localparam int          BYTE_W       = 8;

    // status fields
    localparam int          ST_BANDS_LSB = 0;
    localparam int          ST_SPEED_LSB = 8;
    localparam int          ST_FULL      = 16;
    localparam int          ST_LATCHED   = 17;
    localparam int          ST_DRIVE     = 18;

    // reset values
    localparam logic [31:0] THR_RST      = 32'h0000_0000;
    localparam logic [31:0] LIMIT_RST    = 32'h6464_6464;

    typedef logic [1:0] ibsl_band_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ACK  = 2'b01
    } ibsl_bus_t;

endpackage

//--- hdl/ibsl_limiter.sv
`timescale 1ns/100ps
// Operation
// - input 2 may be sampled only at drive entry
// - input 3 has its own entry-sample option
// - option off: input evaluated continuously
// - each local input: three thresholds, debounce
// - lower threshold splits band 0/1, 0..100%
// - middle threshold splits band 1/2, 0..100%
// - upper threshold splits band 2/3, 0..100%
// - new band only after stable debounce time
// - five drive-inhibit slots, any input source
// - slot source is off or 2..33
// - slot set off never becomes active
// - slot follows band of chosen input
// - four speed limits per slot, per band
// - zero limit: full inhibit, brakes held
// - nonzero limit caps speed at that value
// - non-latching: drive resumes when cause leaves
// - latching: inhibit held until power cycle
// - alarm option sounds during full inhibit
// - level maps to exactly one of four bands
module ibsl_limiter
    import ibsl_pkg::*;
#(
    parameter int CYC_MS = CYCLES_PER_MS
) (
    // clock and reset
    input  wire logic                       clock,
    input  wire logic                       srst,
    // avalon-mm slave
    input  wire logic [ADDR_W-1:0]          avs_address,
    input  wire logic                       avs_read,
    input  wire logic                       avs_write,
    input  wire logic [3:0]                 avs_byteenable,
    input  wire logic [31:0]                avs_writedata,
    output logic [31:0]                     avs_readdata,
    output logic                            avs_waitrequest,
    // inhibit levels and drive mode
    input  wire logic [N_LOCAL*PCT_W-1:0]   local_level,
    input  wire logic [N_REMOTE*2-1:0]      remote_band,
    input  wire logic                       drive_mode,
    // drive limiting results
    output logic [PCT_W-1:0]                speed_limit,
    output logic                            full_inhibit,
    output logic                            brake_hold,
    output logic                            inhibit_alarm,
    output logic [N_SLOT-1:0]               slot_active
);

    // ****************************************************************
    // decoding functions
    // ****************************************************************
    // level below a threshold stays in the lower band
    function automatic ibsl_band_t classify(input logic [PCT_W-1:0] lvl,
                                            input logic [31:0] thr);
        if (lvl < thr[THR_LOW_LSB +: PCT_W])      classify = 2'h0;
        else if (lvl < thr[THR_MID_LSB +: PCT_W]) classify = 2'h1;
        else if (lvl < thr[THR_UP_LSB +: PCT_W])  classify = 2'h2;
        else                                      classify = 2'h3;
    endfunction

    function automatic logic src_valid(input logic [SRC_W-1:0] src);
        src_valid = (src >= SRC_FIRST) && (src <= SRC_LAST);
    endfunction

    // word slot inside an array of registers, or -1 if out of range
    function automatic int word_idx(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] base, input int n);
        int d;
        d = (int'(a) - int'(base)) >> 2;
        word_idx = (a >= base && d < n && a[1:0] == 2'h0) ? d : -1;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw, input logic [3:0] be);
        merge = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) merge[b*BYTE_W +: BYTE_W] = nw[b*BYTE_W +: BYTE_W];
        end
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************
    ibsl_bus_t                 bus_r, bus_nxt;
    logic                      wreq_r, wreq_nxt;
    logic [31:0]               rdata_r, rdata_nxt;
    logic                      wr_en;
    logic [CTRL_W-1:0]         ctrl_r, ctrl_nxt;
    logic [31:0]               thr_r [N_LOCAL];
    logic [31:0]               thr_nxt [N_LOCAL];
    logic [SRC_W-1:0]          assign_r [N_SLOT];
    logic [SRC_W-1:0]          assign_nxt [N_SLOT];
    logic [31:0]               limit_r [N_SLOT];
    logic [31:0]               limit_nxt [N_SLOT];
    logic [PRE_W-1:0]          pre_r, pre_nxt;
    logic                      tick_r, tick_nxt;
    ibsl_band_t                cand_r [N_LOCAL];
    ibsl_band_t                cand_nxt [N_LOCAL];
    ibsl_band_t                stable_r [N_LOCAL];
    ibsl_band_t                stable_nxt [N_LOCAL];
    logic [CNT_W-1:0]          cnt_r [N_LOCAL];
    logic [CNT_W-1:0]          cnt_nxt [N_LOCAL];
    logic [CNT_W-1:0]          target [N_LOCAL];
    ibsl_band_t                held_r [2];
    ibsl_band_t                held_nxt [2];
    ibsl_band_t                use_band [N_LOCAL];
    logic                      drive_d_r;
    logic [PCT_W-1:0]          eff_lim;
    logic [PCT_W-1:0]          slot_lim [N_SLOT];
    logic [N_SLOT-1:0]         act;
    logic                      latch_r, latch_nxt;
    logic [PCT_W-1:0]          speed_r, speed_nxt;
    logic                      full_r, full_nxt;
    logic                      alarm_r, alarm_nxt;
    logic [N_SLOT-1:0]         act_r;
    logic [31:0]               rd_mux;

    // ****************************************************************
    // bus slave: one wait cycle, then answer
    // ****************************************************************
    // read mux; unmapped addresses read as zero
    always_comb begin
        int i;
        i = 0;
        rd_mux = 32'h0000_0000;
        if (avs_address == REG_CTRL) begin
            rd_mux[CTRL_W-1:0] = ctrl_r;
        end else if (avs_address == REG_STATUS) begin
            for (int j = 0; j < N_LOCAL; j++) rd_mux[ST_BANDS_LSB + 2*j +: 2] = use_band[j];
            rd_mux[ST_SPEED_LSB +: PCT_W] = speed_r;
            rd_mux[ST_FULL]               = full_r;
            rd_mux[ST_LATCHED]            = latch_r;
            rd_mux[ST_DRIVE]              = drive_d_r;
        end else begin
            i = word_idx(avs_address, REG_THR, N_LOCAL);
            if (i >= 0) rd_mux = thr_r[i];
            i = word_idx(avs_address, REG_ASSIGN, N_SLOT);
            if (i >= 0) rd_mux[SRC_W-1:0] = assign_r[i];
            i = word_idx(avs_address, REG_LIMIT, N_SLOT);
            if (i >= 0) rd_mux = limit_r[i];
        end
    end

    // bus fsm: a write lands at the edge where waitrequest is seen low
    always_comb begin
        bus_nxt   = bus_r;
        wreq_nxt  = 1'b1;
        rdata_nxt = rdata_r;
        wr_en     = 1'b0;
        case (bus_r)
            BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    bus_nxt   = BUS_ACK;
                    wreq_nxt  = 1'b0;
                    rdata_nxt = avs_read ? rd_mux : 32'h0000_0000;
                end
            end
            BUS_ACK: begin
                bus_nxt = BUS_IDLE;
                wr_en   = avs_write;
            end
            default: begin
                bus_nxt = BUS_IDLE;
            end
        endcase
    end

    // configuration writes; values over range are kept but clamped in use
    always_comb begin
        int i;
        i = 0;
        ctrl_nxt   = ctrl_r;
        thr_nxt    = thr_r;
        assign_nxt = assign_r;
        limit_nxt  = limit_r;
        if (wr_en) begin
            if (avs_address == REG_CTRL && avs_byteenable[0]) begin
                ctrl_nxt = avs_writedata[CTRL_W-1:0];
            end
            i = word_idx(avs_address, REG_THR, N_LOCAL);
            if (i >= 0) thr_nxt[i] = merge(thr_r[i], avs_writedata, avs_byteenable);
            i = word_idx(avs_address, REG_ASSIGN, N_SLOT);
            if (i >= 0 && avs_byteenable[0]) assign_nxt[i] = avs_writedata[SRC_W-1:0];
            i = word_idx(avs_address, REG_LIMIT, N_SLOT);
            if (i >= 0) limit_nxt[i] = merge(limit_r[i], avs_writedata, avs_byteenable);
        end
    end

    // ****************************************************************
    // band detection and debounce
    // ****************************************************************
    // millisecond tick from the system clock
    always_comb begin
        tick_nxt = 1'b0;
        pre_nxt  = pre_r + 1'b1;
        if (pre_r == PRE_W'(CYC_MS - 1)) begin
            pre_nxt  = '0;
            tick_nxt = 1'b1;
        end
    end

    // any raw change restarts the stable count; zero time passes at once
    always_comb begin
        ibsl_band_t raw;
        logic [3:0] code;
        raw  = 2'h0;
        code = 4'h0;
        for (int j = 0; j < N_LOCAL; j++) begin
            raw        = classify(local_level[j*PCT_W +: PCT_W], thr_r[j]);
            code       = thr_r[j][THR_DEB_LSB +: 4];
            if (code > DEB_CODE_MAX) code = DEB_CODE_MAX;
            target[j]  = CNT_W'(code * DEB_STEP_MS);
            cand_nxt[j]   = cand_r[j];
            stable_nxt[j] = stable_r[j];
            cnt_nxt[j]    = cnt_r[j];
            if (raw != cand_r[j]) begin
                cand_nxt[j] = raw;
                cnt_nxt[j]  = '0;
            end else if (cnt_r[j] >= target[j]) begin
                stable_nxt[j] = cand_r[j];
            end else if (tick_r) begin
                cnt_nxt[j] = cnt_r[j] + 1'b1;
            end
        end
    end

    // inputs 2 and 3 may be frozen at drive entry; the entry cycle
    // itself still sees the live band so nothing is lost at the edge
    always_comb begin
        for (int j = 0; j < 2; j++) begin
            held_nxt[j] = (drive_mode && !drive_d_r) ? stable_r[j] : held_r[j];
        end
        use_band[0] = (ctrl_r[CTRL_ENTRY2] && drive_d_r) ? held_r[0] : stable_r[0];
        use_band[1] = (ctrl_r[CTRL_ENTRY3] && drive_d_r) ? held_r[1] : stable_r[1];
        use_band[2] = stable_r[2];
        use_band[3] = stable_r[3];
    end

    // ****************************************************************
    // slots and drive limiting
    // ****************************************************************
    // lowest limit of the active slots; over-range limits read as full
    always_comb begin
        ibsl_band_t       b;
        logic [PCT_W-1:0] l;
        int               n;
        b       = 2'h0;
        l       = PCT_ZERO;
        n       = 0;
        eff_lim = PCT_FULL;
        for (int k = 0; k < N_SLOT; k++) begin
            act[k] = src_valid(assign_r[k]);
            n      = int'(assign_r[k]) - int'(SRC_FIRST);
            if (!act[k])                        b = 2'h0;
            else if (assign_r[k] < SRC_REMOTE)  b = use_band[n[1:0]];
            else b = remote_band[(int'(assign_r[k]) - int'(SRC_REMOTE))*2 +: 2];
            l = limit_r[k][int'(b)*BYTE_W +: PCT_W];
            if (l > PCT_FULL) l = PCT_FULL;
            slot_lim[k] = l;
            if (act[k] && l < eff_lim) eff_lim = l;
        end
    end

    // full inhibit on zero limit; latched copy is cleared by reset only
    always_comb begin
        latch_nxt = latch_r | ((eff_lim == PCT_ZERO) & ctrl_r[CTRL_LATCH]);
        full_nxt  = (eff_lim == PCT_ZERO) | latch_r;
        speed_nxt = full_nxt ? PCT_ZERO : eff_lim;
        alarm_nxt = full_nxt & ctrl_r[CTRL_ALARM];
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge clock) begin
        if (srst) begin
            bus_r     <= BUS_IDLE;
            wreq_r    <= 1'b1;
            rdata_r   <= 32'h0000_0000;
            ctrl_r    <= '0;
            pre_r     <= '0;
            tick_r    <= 1'b0;
            drive_d_r <= 1'b0;
            latch_r   <= 1'b0;
            speed_r   <= PCT_FULL;
            full_r    <= 1'b0;
            alarm_r   <= 1'b0;
            act_r     <= '0;
            for (int j = 0; j < N_LOCAL; j++) begin
                thr_r[j]    <= THR_RST;
                cand_r[j]   <= 2'h0;
                stable_r[j] <= 2'h0;
                cnt_r[j]    <= '0;
            end
            for (int j = 0; j < 2; j++) held_r[j] <= 2'h0;
            for (int k = 0; k < N_SLOT; k++) begin
                assign_r[k] <= SRC_OFF;
                limit_r[k]  <= LIMIT_RST;
            end
        end else begin
            bus_r     <= bus_nxt;
            wreq_r    <= wreq_nxt;
            rdata_r   <= rdata_nxt;
            ctrl_r    <= ctrl_nxt;
            pre_r     <= pre_nxt;
            tick_r    <= tick_nxt;
            drive_d_r <= drive_mode;
            latch_r   <= latch_nxt;
            speed_r   <= speed_nxt;
            full_r    <= full_nxt;
            alarm_r   <= alarm_nxt;
            act_r     <= act;
            thr_r     <= thr_nxt;
            cand_r    <= cand_nxt;
            stable_r  <= stable_nxt;
            cnt_r     <= cnt_nxt;
            held_r    <= held_nxt;
            assign_r  <= assign_nxt;
            limit_r   <= limit_nxt;
        end
    end

    // outputs straight from flops
    assign avs_waitrequest = wreq_r;
    assign avs_readdata    = rdata_r;
    assign speed_limit     = speed_r;
    assign full_inhibit    = full_r;
    assign brake_hold      = full_r;
    assign inhibit_alarm   = alarm_r;
    assign slot_active     = act_r;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    a_off_slot_idle: assert property (assign_r[0] == SRC_OFF |=> !slot_active[0])
        else $error("slot set off became active");
    a_zero_full_brake: assert property (eff_lim == PCT_ZERO |=> full_inhibit
                                        && brake_hold && speed_limit == PCT_ZERO)
        else $error("zero limit did not inhibit drive");
    a_cap_speed: assert property (eff_lim != PCT_ZERO && !latch_r |=> !full_inhibit
                                  && speed_limit == $past(eff_lim))
        else $error("speed not capped at active limit");
    a_nonlatch_release: assert property (!ctrl_r[CTRL_LATCH] && !latch_r ##1
                                         eff_lim != PCT_ZERO |=> !full_inhibit)
        else $error("non-latching inhibit did not release");
    a_latch_hold: assert property (full_inhibit && ctrl_r[CTRL_LATCH] |=> full_inhibit [*2])
        else $error("latched inhibit released");
    a_alarm_follow: assert property (inhibit_alarm == (full_inhibit
                                     && $past(ctrl_r[CTRL_ALARM])))
        else $error("alarm does not follow inhibit and option");
    a_entry_hold: assert property (drive_d_r && drive_mode |=> $stable(held_r[0])
                                   && $stable(held_r[1]))
        else $error("entry sample changed during drive");
    a_deb_wait: assert property ($changed(stable_r[0]) |-> $past(cnt_r[0] >= target[0]))
        else $error("band taken before debounce elapsed");
    a_deb_restart: assert property ($changed(cand_r[3]) |-> cnt_r[3] == '0)
        else $error("debounce count not restarted");
    a_min_limit: assert property (act[1] && act[0] |=> speed_limit <= $past(slot_lim[0])
                                  && speed_limit <= $past(slot_lim[1]))
        else $error("limit above an active slot limit");

    c_full_inhibit: cover property (!full_inhibit ##1 full_inhibit);
    c_latched: cover property (latch_r && eff_lim != PCT_ZERO);
    c_write_done: cover property (avs_write && !avs_waitrequest);
    c_entry_frozen: cover property (ctrl_r[CTRL_ENTRY2] && drive_d_r && held_r[0] != stable_r[0]);

endmodule

//--- test/ibsl_inhibit_net.sv
`timescale 1ns/100ps
// ****************************************************************
// switch and resistor network on the inhibit inputs
// ****************************************************************
module ibsl_inhibit_net
    import ibsl_pkg::*;
(
    // clock
    input  wire logic                     clock,
    // switch positions set by the bench
    input  wire logic [N_LOCAL*PCT_W-1:0] level_set,
    input  wire logic [N_REMOTE*2-1:0]    remote_set,
    // what the controller sees
    output logic [N_LOCAL*PCT_W-1:0]      local_level,
    output logic [N_REMOTE*2-1:0]         remote_band
);
    // ladder settles a cycle after a switch moves; a network always drives
    always_ff @(posedge clock) begin
        local_level <= level_set;
        remote_band <= remote_set;
    end
endmodule

//--- test/inhibit_band_speed_limiter_bench.sv
`timescale 1ns/100ps
// ****************************************************************
// bench for the inhibit band speed limiter
// ****************************************************************
module inhibit_band_speed_limiter_bench
    import ibsl_pkg::*;
;
    logic                     clock       = 1'b0;
    logic                     srst        = 1'b1;
    logic [ADDR_W-1:0]        avs_address = 8'h00;
    logic                     avs_read    = 1'b0;
    logic                     avs_write   = 1'b0;
    logic [31:0]              avs_writedata = 32'h0;
    logic [31:0]              avs_readdata;
    logic                     avs_waitrequest;
    logic [N_LOCAL*PCT_W-1:0] level_set   = '0;
    logic [N_REMOTE*2-1:0]    remote_set  = '0;
    logic [N_LOCAL*PCT_W-1:0] local_level;
    logic [N_REMOTE*2-1:0]    remote_band;
    logic                     drive_mode  = 1'b0;
    logic [PCT_W-1:0]         speed_limit;
    logic                     full_inhibit;
    logic                     brake_hold;
    logic                     inhibit_alarm;
    logic [N_SLOT-1:0]        slot_active;
    logic [31:0]              rd;
    int                       miscompares = 0;
    int                       num_checks  = 0;
    logic [6:0] lvl_tab [7] = '{7'h0B, 7'h0C, 7'h21, 7'h22, 7'h35, 7'h36, 7'h64};
    logic [6:0] spd_tab [7] = '{7'h64, 7'h32, 7'h32, 7'h19, 7'h19, 7'h00, 7'h00};

    // short ms so debounce code 1 is 200 cycles
    ibsl_limiter #(.CYC_MS(4)) dut (
        .clock(clock), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_byteenable(4'hF), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .local_level(local_level), .remote_band(remote_band), .drive_mode(drive_mode),
        .speed_limit(speed_limit), .full_inhibit(full_inhibit), .brake_hold(brake_hold),
        .inhibit_alarm(inhibit_alarm), .slot_active(slot_active));

    ibsl_inhibit_net net (
        .clock(clock), .level_set(level_set), .remote_set(remote_set),
        .local_level(local_level), .remote_band(remote_band));

    always #25 clock = ~clock;

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= ~wr;
        avs_writedata <= d;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        chk("bus latency", 32'(n), 32'h2);
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(nm, rd, exp);
    endtask

    // write, then let the limit path settle
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
        cyc(6);
    endtask

    task automatic outs(input logic [6:0] s, input logic f, input logic al);
        chk("speed_limit", 32'(speed_limit), 32'(s));
        chk("full_inhibit", 32'(full_inhibit), 32'(f));
        chk("brake_hold", 32'(brake_hold), 32'(f));
        chk("inhibit_alarm", 32'(inhibit_alarm), 32'(al));
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // watchdog: whole run is under a thousand cycles
    initial begin
        cyc(20000);
        miscompares++;
        end_sim();
    end

    initial begin
        cyc(20);
        srst <= 1'b0;
        cyc(1);
        outs(7'h64, 1'b0, 1'b0);
        rdchk("limit reset", REG_LIMIT, LIMIT_RST);
        rdchk("thr reset", REG_THR, THR_RST);
        bus(1'b1, 8'hF0, 32'hFFFF_FFFF);
        rdchk("unmapped", 8'hF0, 32'h0);
        // ****************************************************************
        // band edges on input 2 through slot a, alarm on
        // ****************************************************************
        wr(REG_CTRL, 32'h8);
        wr(REG_THR, 32'h0036_220C);
        wr(REG_ASSIGN, 32'h2);
        wr(REG_LIMIT, 32'h0019_3264);
        foreach (lvl_tab[k]) begin
            level_set[6:0] <= lvl_tab[k];
            cyc(6);
            outs(spd_tab[k], spd_tab[k] == 7'h00, spd_tab[k] == 7'h00);
        end
        level_set[6:0] <= 7'h0B;
        cyc(6);
        outs(7'h64, 1'b0, 1'b0);
        // ****************************************************************
        // remote source, off selectors, input 5, lowest limit wins
        // ****************************************************************
        remote_set[54 +: 2] <= 2'h3;
        wr(REG_ASSIGN + 8'h04, 32'h21);
        wr(REG_LIMIT + 8'h04, 32'h1E64_6464);
        wr(REG_ASSIGN + 8'h08, 32'h1);
        wr(REG_LIMIT + 8'h08, 32'h0);
        wr(REG_ASSIGN + 8'h0C, 32'h22);
        wr(REG_LIMIT + 8'h0C, 32'h0);
        wr(REG_THR + 8'h0C, 32'h0046_3C32);
        wr(REG_LIMIT + 8'h10, 32'h6464_0A64);
        wr(REG_ASSIGN + 8'h10, 32'h5);
        chk("slot_active", 32'(slot_active), 32'h13);
        outs(7'h1E, 1'b0, 1'b0);
        level_set[27:21] <= 7'h37;
        cyc(6);
        outs(7'h0A, 1'b0, 1'b0);
        level_set[27:21] <= 7'h00;
        remote_set[54 +: 2] <= 2'h0;
        cyc(6);
        outs(7'h64, 1'b0, 1'b0);
        // ****************************************************************
        // debounce of 50 ms, with a one cycle bounce that restarts it
        // ****************************************************************
        wr(REG_THR, 32'h0136_220C);
        level_set[6:0] <= 7'h22;
        cyc(150);
        outs(7'h64, 1'b0, 1'b0);
        level_set[6:0] <= 7'h0B;
        cyc(1);
        level_set[6:0] <= 7'h22;
        cyc(150);
        outs(7'h64, 1'b0, 1'b0);
        cyc(80);
        outs(7'h19, 1'b0, 1'b0);
        wr(REG_THR, 32'h0036_220C);
        // ****************************************************************
        // entry sampling of inputs 2 and 3, slot d on input 3
        // ****************************************************************
        wr(REG_THR + 8'h04, 32'h0036_220C);
        wr(REG_ASSIGN + 8'h0C, 32'h3);
        wr(REG_LIMIT + 8'h0C, 32'h0019_3264);
        level_set[13:0] <= 14'h0000 | {7'h0B, 7'h0B};
        wr(REG_CTRL, 32'hB);
        drive_mode <= 1'b1;
        cyc(3);
        level_set[13:0] <= {7'h36, 7'h36};
        cyc(6);
        outs(7'h64, 1'b0, 1'b0);
        wr(REG_CTRL, 32'hA);
        outs(7'h00, 1'b1, 1'b1);
        level_set[6:0] <= 7'h0B;
        cyc(6);
        outs(7'h64, 1'b0, 1'b0);
        wr(REG_CTRL, 32'h8);
        outs(7'h00, 1'b1, 1'b1);
        // ****************************************************************
        // latching, alarm off; only a reset clears it
        // ****************************************************************
        wr(REG_CTRL, 32'h4);
        level_set[13:7] <= 7'h0B;
        cyc(6);
        outs(7'h00, 1'b1, 1'b0);
        rdchk("status", REG_STATUS, 32'h0007_0030);
        srst <= 1'b1;
        cyc(2);
        srst <= 1'b0;
        drive_mode <= 1'b0;
        cyc(2);
        outs(7'h64, 1'b0, 1'b0);
        end_sim();
    end
endmodule
